/* File: bench/drp_checker.sv */
// Purpose: link assertions for the serial register port
// Assumes: host straps by method 2; sclk far slower than clk_sys
// Notes: link edges are seen by oversampling on clk_sys
`timescale 1ns/10ps
module drp_checker
  import drp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sdio,
  input wire logic sen_n,
  input wire logic rst_n,
  input wire logic strap_a,
  input wire logic strap_b,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic sdio_host_oe
);
  logic       tw;
  logic [5:0] rise_reg;
  logic [8:0] shift_reg;
  assign tw = strap_a & strap_b;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // frame bit counter restarts on START or while the select is idle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rise_reg <= 6'h00;
      shift_reg <= 9'h000;
    end else if (tw ? (sclk && $fell(sdio)) : sen_n) begin
      rise_reg <= 6'h00;
    end else if ($rose(sclk)) begin
      rise_reg <= rise_reg + 6'h01;
      shift_reg <= {shift_reg[7:0], sdio};
    end
  end
  a_open_drain:
    assert property (tw && rst_n |-> !(sdio_dev_oe && sdio_dev_o))
    else $error("device drove data high in two-wire mode");
  a_reset_quiet:
    assert property (!rst_n |-> !sdio_dev_oe) else $error("device drove data in reset");
  a_single_driver:
    assert property (!(sdio_host_oe && sdio_dev_oe)) else $error("both ends drive data");
  a_drive_on_low:
    assert property (tw && $rose(sdio_dev_oe) |-> !sclk) else $error("drive began, clock high");
  a_select_release:
    assert property (!tw && sen_n && $rose(sclk) |-> ##[0:2] !sdio_dev_oe)
    else $error("device kept data after select rose");
  a_frame_length:
    assert property (!tw && $rose(sen_n) |-> rise_reg == 6'h19) else $error("frame length");
  a_chip_addr:
    assert property (!tw && $rose(sclk) && rise_reg == 6'h09
      |-> {shift_reg[8:6], shift_reg[4]} == DRP_CHIP_ADDR) else $error("chip address");
  a_addr_ack:
    assert property (tw && $rose(sclk) && rise_reg == 6'h08
      |-> shift_reg[7:1] == DRP_DEV_ADDR && !sdio) else $error("address byte or ack");
endmodule

/* File: bench/dual_mode_serial_register_port_test.sv */
// Purpose: runs both ends of the serial register port through host commands
// Assumes: host straps the mode from cfg_two_wire
// Notes: short quarter and reset counts keep the run brief
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module dual_mode_serial_register_port_test
  import drp_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b0;
  logic        cfg_two_wire = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_read = 1'b0;
  logic [3:0]  cmd_addr = 4'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        cmd_ready, rsp_valid, reg_wr_pulse, mode_two_wire;
  logic [15:0] rsp_rdata, reg_wr_data, seen_data;
  logic [3:0]  reg_wr_addr, seen_addr;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  drp_if drp_if_inst ();
  // three cycles a quarter: the host's three-stage data sampler settles before capture
  drp_host #(.QTR_CYC(3), .RST_CYC(2)) drp_host_inst (.bus(drp_if_inst.host),
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_two_wire(cfg_two_wire), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  drp_device drp_device_inst (.bus(drp_if_inst.dev), .clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .mode_two_wire(mode_two_wire));
  drp_checker drp_checker_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(drp_if_inst.sclk),
    .sdio(drp_if_inst.sdio), .sen_n(drp_if_inst.sen_n), .rst_n(drp_if_inst.rst_n),
    .strap_a(drp_if_inst.strap_a), .strap_b(drp_if_inst.strap_b),
    .sdio_dev_o(drp_if_inst.sdio_dev_o), .sdio_dev_oe(drp_if_inst.sdio_dev_oe),
    .sdio_host_oe(drp_if_inst.sdio_host_oe));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (reg_wr_pulse === 1'b1) begin
      seen_addr = reg_wr_addr;
      seen_data = reg_wr_data;
    end
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic two_wire);
    cfg_two_wire <= two_wire;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  // one command, waiting on ready and response under a bound
  task automatic xfer(input logic rd, input logic [3:0] addr, input logic [15:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= addr;
    cmd_wdata <= wd;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    @(negedge clk_sys);
    `CHK("busy", 1'b0, cmd_ready)
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("response", 1'b1, rsp_valid)
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic t_three_wire();
    do_reset(1'b0);
    xfer(1'b0, 4'h5, 16'hA5C3);
    `CHK("mode", 1'b0, mode_two_wire)
    `CHK("write addr", 4'h5, seen_addr)
    `CHK("write data", 16'hA5C3, seen_data)
    xfer(1'b1, 4'h5, 16'h0000);
    `CHK("read data", 16'hA5C3, rsp_rdata)
    xfer(1'b1, 4'h9, 16'h0000);
    `CHK("default", DRP_REG_RESET, rsp_rdata)
    xfer(1'b0, DRP_RD_FIRST, 16'h5A3C);
    `CHK("last addr", DRP_RD_FIRST, seen_addr)
    `CHK("last data", 16'h5A3C, seen_data)
  endtask
  task automatic t_two_wire();
    do_reset(1'b1);
    xfer(1'b1, 4'h0, 16'h0000);
    `CHK("mode", 1'b1, mode_two_wire)
    `CHK("cleared read", DRP_REG_RESET, rsp_rdata)
    xfer(1'b0, 4'h0, 16'hC35A);
    `CHK("burst addr", DRP_WR_FIRST, seen_addr)
    `CHK("burst data", 16'hC35A, seen_data)
  endtask
  initial begin
    t_three_wire();
    t_two_wire();
    conclude();
  end
endmodule

/* File: hw/drp_device.sv */
// Purpose : device end; register file reached over a 3-wire or 2-wire link
// Assumes : link logic is clocked by sclk, reset by the active-low reset pin
// Notes   : every register write is reported on clk_sys through a toggle
//
// How it works
// - low select on rising clock starts 3-wire
// - nine-bit word: chip 0110, direction, register
// - order: three chip bits, direction, rest
// - 3-wire write: sixteen data bits on rising
// - 3-wire read: turnaround, sixteen bits out rising
// - select high ends transfer; 25 clocks
// - registers need no reference clock or power
// - 2-wire lines only pulled low
// - START: data falls while clock high
// - address byte 0010000 plus direction bit
// - address match acknowledged one cycle low
// - written bytes latched, each acknowledged
// - write burst starts 02h, wraps to 00h
// - STOP ends transfer; byte counter reloads on address match
// - read bytes change on falling edges
// - read burst starts 0Ah, wraps to 00h
// - controller acknowledges to continue reading
// - reset pin low clears registers, disables port
// - strap a low: select pin chooses mode
// - strap a high: strap b chooses mode

`timescale 1ns/10ps

module drp_device
  import drp_pkg::*;
#(
  parameter logic [DRP_REG_W-1:0] REG_RESET = DRP_REG_RESET
) (
  drp_if.dev                      bus,
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  output logic                    reg_wr_pulse,
  output logic [3:0]              reg_wr_addr,
  output logic [DRP_REG_W-1:0]    reg_wr_data,
  output logic                    mode_two_wire
);

  typedef enum logic [6:0] {
    DRP_D_IDLE = 7'h01,
    DRP_D_CTRL = 7'h02,
    DRP_D_DATA = 7'h04,
    DRP_D_ADDR = 7'h08,
    DRP_D_WR   = 7'h10,
    DRP_D_RD   = 7'h20,
    DRP_D_SKIP = 7'h40
  } drp_dst_t;

  typedef struct packed {
    logic [DRP_REG_N-1:0][DRP_REG_W-1:0] regs;
    drp_dst_t                            st;
    logic [4:0]                          cnt;
    logic [15:0]                         sh;
    logic                                rd;
    logic [3:0]                          ra;
    logic [4:0]                          ptr;
    logic                                ack;
    logic                                tx_en;
    logic [7:0]                          tx;
    logic                                o3;
    logic                                oe3;
    logic                                start_seen;
    logic                                stop_seen;
    logic                                wr_t;
    logic [3:0]                          wr_a;
    logic [DRP_REG_W-1:0]                wr_d;
  } drp_dlink_t;

  typedef struct packed {
    logic [2:0]           wr_s;
    logic                 wr_acc;
    logic [2:0]           md_s;
    logic                 md;
    logic                 pulse;
    logic [3:0]           a;
    logic [DRP_REG_W-1:0] d;
  } drp_dsys_t;

  localparam drp_dlink_t LINK_RST = '{regs: {DRP_REG_N{REG_RESET}}, st: DRP_D_IDLE,
                                      default: '0};

  drp_dlink_t lr_reg;
  drp_dlink_t lr_next;
  drp_dsys_t  sr_reg;
  drp_dsys_t  sr_next;
  logic       mode_two_reg;
  logic       start_t_reg;
  logic       stop_t_reg;
  logic       oe2_reg;

  // ---------------------------------------------------------------
  // bus mode strap, caught on the release of the reset pin
  // ---------------------------------------------------------------
  always_ff @(posedge bus.rst_n) begin
    mode_two_reg <= bus.strap_a ? bus.strap_b : bus.sen_n;
  end

  // ---------------------------------------------------------------
  // START / STOP detectors, clocked by the data line itself
  // ---------------------------------------------------------------
  // sclk gives no rising edge between START and the first bit, so the data
  // line clocks these toggles; each is stable for half a clock before use
  always_ff @(negedge bus.sdio or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      start_t_reg <= 1'b0;
    end else if (bus.sclk) begin
      start_t_reg <= !start_t_reg;
    end
  end

  always_ff @(posedge bus.sdio or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      stop_t_reg <= 1'b0;
    end else if (bus.sclk) begin
      stop_t_reg <= !stop_t_reg;
    end
  end

  // ---------------------------------------------------------------
  // link side: state sampled on rising sclk, two-wire drive on falling sclk
  // ---------------------------------------------------------------
  always_comb begin
    logic [8:0] cw;
    logic [3:0] ri;
    logic       start;
    logic       stop;
    cw    = {lr_reg.sh[7:0], bus.sdio};
    ri    = lr_reg.ptr[4:1];
    start = (start_t_reg != lr_reg.start_seen);
    stop  = (stop_t_reg != lr_reg.stop_seen);
    lr_next            = lr_reg;
    lr_next.start_seen = start_t_reg;
    lr_next.stop_seen  = stop_t_reg;
    if (!mode_two_reg) begin
      if (bus.sen_n) begin
        lr_next.st  = DRP_D_IDLE;
        lr_next.cnt = 5'h00;
        lr_next.oe3 = 1'b0;
      end else begin
        case (lr_reg.st)
          DRP_D_IDLE: begin
            lr_next.sh  = {15'h0000, bus.sdio};
            lr_next.cnt = 5'h01;
            lr_next.st  = DRP_D_CTRL;
          end
          DRP_D_CTRL: begin
            lr_next.sh  = {lr_reg.sh[14:0], bus.sdio};
            lr_next.cnt = lr_reg.cnt + 5'h01;
            if (lr_reg.cnt == DRP_3W_CTRL) begin
              // word is A7 A6 A5, direction, A4, A3..A0
              if ({cw[8:6], cw[4]} == DRP_CHIP_ADDR) begin
                lr_next.rd = cw[5];
                lr_next.ra = cw[3:0];
                lr_next.sh = lr_reg.regs[cw[3:0]];
                lr_next.st = DRP_D_DATA;
              end else begin
                lr_next.st = DRP_D_SKIP;
              end
            end
          end
          DRP_D_DATA: begin
            if (lr_reg.cnt <= DRP_3W_DATA) begin
              lr_next.cnt = lr_reg.cnt + 5'h01;
              if (lr_reg.rd) begin
                lr_next.o3  = lr_reg.sh[15];
                lr_next.oe3 = 1'b1;
                lr_next.sh  = {lr_reg.sh[14:0], 1'b0};
              end else begin
                lr_next.sh = {lr_reg.sh[14:0], bus.sdio};
                if (lr_reg.cnt == DRP_3W_DATA) begin
                  lr_next.regs[lr_reg.ra] = {lr_reg.sh[14:0], bus.sdio};
                  lr_next.wr_t = !lr_reg.wr_t;
                  lr_next.wr_a = lr_reg.ra;
                  lr_next.wr_d = {lr_reg.sh[14:0], bus.sdio};
                end
              end
            end
          end
          default: begin
            lr_next.st = DRP_D_SKIP;
          end
        endcase
      end
    end else if (start) begin
      lr_next.sh    = {15'h0000, bus.sdio};
      lr_next.cnt   = 5'h01;
      lr_next.ack   = 1'b0;
      lr_next.tx_en = 1'b0;
      lr_next.st    = DRP_D_ADDR;
    end else if (stop) begin
      lr_next.st    = DRP_D_IDLE;
      lr_next.ack   = 1'b0;
      lr_next.tx_en = 1'b0;
    end else begin
      case (lr_reg.st)
        DRP_D_ADDR: begin
          if (lr_reg.cnt == DRP_ACK_SLOT) begin
            lr_next.ack = 1'b0;
            lr_next.cnt = 5'h00;
            if (lr_reg.rd) begin
              lr_next.tx    = lr_reg.ptr[0] ? lr_reg.regs[ri][7:0] : lr_reg.regs[ri][15:8];
              lr_next.tx_en = 1'b1;
              lr_next.ptr   = lr_reg.ptr + 5'h01;
              lr_next.st    = DRP_D_RD;
            end else begin
              lr_next.st = DRP_D_WR;
            end
          end else begin
            lr_next.sh  = {lr_reg.sh[14:0], bus.sdio};
            lr_next.cnt = lr_reg.cnt + 5'h01;
            if (lr_reg.cnt == DRP_BYTE_END) begin
              if (cw[7:1] == DRP_DEV_ADDR) begin
                lr_next.ack = 1'b1;
                lr_next.rd  = bus.sdio;
                // byte counter restarts with every address match
                lr_next.ptr = {(bus.sdio ? DRP_RD_FIRST : DRP_WR_FIRST), 1'b0};
              end else begin
                lr_next.st = DRP_D_SKIP;
              end
            end
          end
        end
        DRP_D_WR: begin
          if (lr_reg.cnt == DRP_ACK_SLOT) begin
            lr_next.ack = 1'b0;
            lr_next.cnt = 5'h00;
          end else begin
            lr_next.sh  = {lr_reg.sh[14:0], bus.sdio};
            lr_next.cnt = lr_reg.cnt + 5'h01;
            if (lr_reg.cnt == DRP_BYTE_END) begin
              if (!lr_reg.ptr[0]) begin
                lr_next.regs[ri][15:8] = cw[7:0];
              end else begin
                lr_next.regs[ri][7:0] = cw[7:0];
              end
              // 5-bit byte pointer wraps from the last low byte to 00h high
              lr_next.ptr  = lr_reg.ptr + 5'h01;
              lr_next.ack  = 1'b1;
              lr_next.wr_t = !lr_reg.wr_t;
              lr_next.wr_a = ri;
              lr_next.wr_d = lr_next.regs[ri];
            end
          end
        end
        DRP_D_RD: begin
          if (lr_reg.cnt == DRP_ACK_SLOT) begin
            lr_next.cnt = 5'h00;
            if (!bus.sdio) begin
              lr_next.tx    = lr_reg.ptr[0] ? lr_reg.regs[ri][7:0] : lr_reg.regs[ri][15:8];
              lr_next.tx_en = 1'b1;
              lr_next.ptr   = lr_reg.ptr + 5'h01;
            end else begin
              lr_next.st = DRP_D_SKIP;
            end
          end else begin
            lr_next.cnt = lr_reg.cnt + 5'h01;
            lr_next.tx  = {lr_reg.tx[6:0], 1'b1};
            if (lr_reg.cnt == DRP_BYTE_END) begin
              lr_next.tx_en = 1'b0;
            end
          end
        end
        default: begin
          lr_next.tx_en = 1'b0;
        end
      endcase
    end
  end

  // reset pin clears registers; no reference clock is involved
  always_ff @(posedge bus.sclk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      lr_reg <= LINK_RST;
    end else begin
      lr_reg <= lr_next;
    end
  end

  // two-wire drive changes only after falling sclk
  always_ff @(negedge bus.sclk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      oe2_reg <= 1'b0;
    end else begin
      oe2_reg <= lr_reg.ack || (lr_reg.tx_en && !lr_reg.tx[7]);
    end
  end

  // open-drain in two-wire mode: only ever pulls low
  assign bus.sdio_dev_o  = mode_two_reg ? 1'b0 : lr_reg.o3;
  assign bus.sdio_dev_oe = mode_two_reg ? oe2_reg : lr_reg.oe3;

  // ---------------------------------------------------------------
  // system side: write report crossed by toggle
  // ---------------------------------------------------------------
  always_comb begin
    sr_next       = sr_reg;
    sr_next.pulse = 1'b0;
    sr_next.wr_s  = {sr_reg.wr_s[1:0], lr_reg.wr_t};
    sr_next.md_s  = {sr_reg.md_s[1:0], mode_two_reg};
    if (sr_reg.wr_s[2] == sr_reg.wr_s[1] && sr_reg.wr_s[2] != sr_reg.wr_acc) begin
      // address and data have been still since the toggle moved
      sr_next.wr_acc = sr_reg.wr_s[2];
      sr_next.pulse  = 1'b1;
      sr_next.a      = lr_reg.wr_a;
      sr_next.d      = lr_reg.wr_d;
    end
    if (sr_reg.md_s[2] == sr_reg.md_s[1]) begin
      sr_next.md = sr_reg.md_s[2];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sr_reg <= '0;
    end else begin
      sr_reg <= sr_next;
    end
  end

  assign reg_wr_pulse  = sr_reg.pulse;
  assign reg_wr_addr   = sr_reg.a;
  assign reg_wr_data   = sr_reg.d;
  assign mode_two_wire = sr_reg.md;

endmodule

/* File: hw/drp_host.sv */
// Purpose : controller end; runs one register transfer per command
// Assumes : cfg_two_wire is static from reset onward
// Notes   : two-wire writes fill register 02h, two-wire reads return 0Ah

`timescale 1ns/10ps

module drp_host
  import drp_pkg::*;
#(
  parameter int QTR_CYC = DRP_QTR_CYC,
  parameter int RST_CYC = DRP_RST_CYC
) (
  drp_if.host               bus,
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         cfg_two_wire,
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire logic         cmd_read,
  input  wire logic [3:0]   cmd_addr,
  input  wire logic [15:0]  cmd_wdata,
  output logic              rsp_valid,
  output logic [15:0]       rsp_rdata
);

  typedef enum logic [5:0] {
    DRP_H_RST   = 6'h01,
    DRP_H_IDLE  = 6'h02,
    DRP_H_START = 6'h04,
    DRP_H_SLOT  = 6'h08,
    DRP_H_STOP  = 6'h10,
    DRP_H_DONE  = 6'h20
  } drp_hst_t;

  typedef struct packed {
    drp_hst_t     st;
    logic [15:0]  rcnt;
    logic [15:0]  qcnt;
    logic [1:0]   q;
    logic [4:0]   slot;
    logic [26:0]  tx;
    logic [26:0]  mask;
    logic         pmask;
    logic         rd;
    logic [15:0]  rx;
    logic [2:0]   sd_s;
    logic         sd;
    logic         sen_n;
    logic         scl;
    logic         sda_o;
    logic         sda_oe;
    logic         rst_n;
    logic         rsp_v;
    logic [15:0]  rsp_d;
  } drp_host_t;

  localparam drp_host_t HOST_RST = '{st: DRP_H_RST, sen_n: 1'b1, scl: 1'b1, pmask: 1'b1,
                                     sd: 1'b1, default: '0};

  drp_host_t hr_reg;
  drp_host_t hr_next;

  // ---------------------------------------------------------------
  // slot sequencer: four quarters per clock, low-low-high-high
  // ---------------------------------------------------------------
  always_comb begin
    logic tick;
    logic do_q0;
    tick  = (hr_reg.qcnt == 16'(QTR_CYC - 1));
    do_q0 = 1'b0;
    hr_next       = hr_reg;
    hr_next.rsp_v = 1'b0;
    hr_next.qcnt  = tick ? 16'h0000 : hr_reg.qcnt + 16'h0001;
    // data pin: three stages, a change counts once the last two agree
    hr_next.sd_s  = {hr_reg.sd_s[1:0], bus.sdio};
    if (hr_reg.sd_s[2] == hr_reg.sd_s[1]) begin
      hr_next.sd = hr_reg.sd_s[2];
    end
    case (hr_reg.st)
      DRP_H_RST: begin
        // device reset held low, straps stable, clock line high
        if (hr_reg.rcnt == 16'(RST_CYC - 1)) begin
          hr_next.rst_n = 1'b1;
          hr_next.st    = DRP_H_IDLE;
        end else begin
          hr_next.rcnt = hr_reg.rcnt + 16'h0001;
        end
      end
      DRP_H_IDLE: begin
        hr_next.qcnt = 16'h0000;
        if (cmd_valid) begin
          hr_next.rd    = cmd_read;
          hr_next.slot  = 5'h00;
          hr_next.q     = 2'h0;
          hr_next.pmask = 1'b1;
          if (cfg_two_wire) begin
            if (cmd_read) begin
              hr_next.tx   = {DRP_DEV_ADDR, 1'b1, 1'b1, 8'hFF, 1'b0, 8'hFF, 1'b1};
              hr_next.mask = {8'hFF, 1'b0, 8'h00, 1'b1, 8'h00, 1'b1};
            end else begin
              hr_next.tx   = {DRP_DEV_ADDR, 1'b0, 1'b1, cmd_wdata[15:8], 1'b1,
                              cmd_wdata[7:0], 1'b1};
              hr_next.mask = {8'hFF, 1'b0, 8'hFF, 1'b0, 8'hFF, 1'b0};
            end
            hr_next.sda_oe = 1'b1;
            hr_next.st     = DRP_H_START;
          end else begin
            hr_next.tx   = {DRP_CHIP_ADDR[3:1], cmd_read, DRP_CHIP_ADDR[0], cmd_addr,
                            cmd_wdata, 2'b00};
            hr_next.mask = {9'h1FF, (cmd_read ? 16'h0000 : 16'hFFFF), 2'b00};
            hr_next.st   = DRP_H_SLOT;
            do_q0        = 1'b1;
          end
        end
      end
      DRP_H_START: begin
        if (tick) begin
          hr_next.st = DRP_H_SLOT;
          do_q0      = 1'b1;
        end
      end
      DRP_H_SLOT: begin
        if (tick) begin
          case (hr_reg.q)
            2'h1: begin
              hr_next.q   = 2'h2;
              hr_next.scl = 1'b1;
              if (cfg_two_wire && hr_reg.rd && !hr_reg.pmask) begin
                hr_next.rx = {hr_reg.rx[14:0], hr_reg.sd};
              end
            end
            2'h3: begin
              if (hr_reg.slot == (cfg_two_wire ? DRP_2W_LAST : DRP_3W_LAST)) begin
                hr_next.q   = 2'h0;
                hr_next.st  = cfg_two_wire ? DRP_H_STOP : DRP_H_DONE;
                hr_next.scl = !cfg_two_wire;
                hr_next.sda_oe = cfg_two_wire;
              end else begin
                hr_next.tx   = {hr_reg.tx[25:0], 1'b0};
                hr_next.mask = {hr_reg.mask[25:0], 1'b0};
                hr_next.slot = hr_reg.slot + 5'h01;
                hr_next.q    = 2'h0;
                do_q0        = 1'b1;
              end
            end
            default: begin
              hr_next.q = hr_reg.q + 2'h1;
            end
          endcase
        end
      end
      DRP_H_STOP: begin
        if (tick) begin
          hr_next.q = hr_reg.q + 2'h1;
          if (hr_reg.q == 2'h1) begin
            hr_next.scl = 1'b1;
          end
          if (hr_reg.q == 2'h3) begin
            hr_next.sda_oe = 1'b0;
            hr_next.st     = DRP_H_DONE;
          end
        end
      end
      DRP_H_DONE: begin
        hr_next.rsp_v = 1'b1;
        hr_next.rsp_d = hr_reg.rx;
        hr_next.st    = DRP_H_IDLE;
      end
      default: begin
        hr_next = HOST_RST;
      end
    endcase
    // falling clock: in 3-wire mode capture the read bit, then present the next one
    if (do_q0) begin
      if (!cfg_two_wire && hr_reg.rd && !hr_reg.pmask && hr_reg.st == DRP_H_SLOT) begin
        hr_next.rx = {hr_reg.rx[14:0], hr_reg.sd};
      end
      hr_next.pmask = hr_next.mask[26];
      hr_next.scl   = 1'b0;
      if (cfg_two_wire) begin
        hr_next.sda_o  = 1'b0;
        hr_next.sda_oe = hr_next.mask[26] && !hr_next.tx[26];
      end else begin
        hr_next.sda_o  = hr_next.tx[26];
        hr_next.sda_oe = hr_next.mask[26];
        hr_next.sen_n  = (hr_next.slot == DRP_3W_LAST);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hr_reg <= HOST_RST;
    end else begin
      hr_reg <= hr_next;
    end
  end

  // sclk is derived from clk_sys; open-drain in two-wire mode
  assign bus.sclk_o       = cfg_two_wire ? 1'b0 : hr_reg.scl;
  assign bus.sclk_oe      = cfg_two_wire ? !hr_reg.scl : 1'b1;
  assign bus.sen_n        = hr_reg.sen_n;
  assign bus.sdio_host_o  = hr_reg.sda_o;
  assign bus.sdio_host_oe = hr_reg.sda_oe;
  assign bus.rst_n        = hr_reg.rst_n;
  assign bus.strap_a      = 1'b1;
  assign bus.strap_b      = cfg_two_wire;
  assign cmd_ready        = (hr_reg.st == DRP_H_IDLE);
  assign rsp_valid        = hr_reg.rsp_v;
  assign rsp_rdata        = hr_reg.rsp_d;

endmodule

/* File: hw/drp_if.sv */
// Purpose : pins between controller and device of the serial register port
// Assumes : pull-ups on clock and data lines
// Notes   : the wire levels are resolved here from the output enables

`timescale 1ns/10ps

interface drp_if;
  logic sclk_o;
  logic sclk_oe;
  logic sen_n;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic rst_n;
  logic strap_a;
  logic strap_b;
  logic sclk;
  logic sdio;

  // a released line floats high through its pull-up
  assign sclk = sclk_oe ? sclk_o : 1'b1;
  assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);

  modport dev (
    input  sclk, sen_n, sdio, rst_n, strap_a, strap_b,
    output sdio_dev_o, sdio_dev_oe
  );

  modport host (
    input  sclk, sdio,
    output sclk_o, sclk_oe, sen_n, sdio_host_o, sdio_host_oe, rst_n, strap_a, strap_b
  );
endinterface

/* File: hw/drp_pkg.sv */
// Purpose : shared constants of the dual mode serial register port
// Assumes : sixteen 16-bit registers, device is the slave on the link
// Notes   : timing figures are controller-side choices; counts derive from them

package drp_pkg;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  localparam int                 DRP_REG_W     = 16;
  localparam int                 DRP_REG_N     = 16;
  localparam logic [15:0]        DRP_REG_RESET = 16'h0000;
  localparam logic [3:0]         DRP_WR_FIRST  = 4'h2;
  localparam logic [3:0]         DRP_RD_FIRST  = 4'hA;

  // ---------------------------------------------------------------
  // addressing and framing
  // ---------------------------------------------------------------
  localparam logic [3:0]         DRP_CHIP_ADDR = 4'h6;
  localparam logic [6:0]         DRP_DEV_ADDR  = 7'h10;
  localparam logic [4:0]         DRP_3W_CTRL   = 5'h08;
  localparam logic [4:0]         DRP_3W_DATA   = 5'h18;
  localparam logic [4:0]         DRP_3W_LAST   = 5'h19;
  localparam logic [4:0]         DRP_2W_LAST   = 5'h1A;
  localparam logic [4:0]         DRP_BYTE_END  = 5'h07;
  localparam logic [4:0]         DRP_ACK_SLOT  = 5'h08;

  // ---------------------------------------------------------------
  // timing of the controller end
  // ---------------------------------------------------------------
  localparam int                 DRP_SYS_NS      = 10;
  localparam int                 DRP_SCLK_NS     = 400;
  localparam int                 DRP_RST_HOLD_NS = 200;
  localparam int                 DRP_QTR_CYC     =
    (DRP_SCLK_NS / (4 * DRP_SYS_NS) < 1) ? 1 : DRP_SCLK_NS / (4 * DRP_SYS_NS);
  localparam int                 DRP_RST_CYC     =
    (DRP_RST_HOLD_NS + DRP_SYS_NS - 1) / DRP_SYS_NS;

endpackage
